/* rtl/crf_cfg.svh */
`ifndef CRF_CFG_SVH
`define CRF_CFG_SVH
`define CRF_NREGS         32
`define CRF_IDX_FRAME     5'h09
`define CRF_IDX_ARG       5'h0A
`define CRF_IDX_STATUS    5'h0B
`define CRF_IDX_STACK     5'h0C
`define CRF_IDX_PCB       5'h0D
`define CRF_IDX_ISTACK    5'h0E
`define CRF_IDX_PC        5'h0F
`define CRF_IDX_PRIV_LO   5'h18
`define CRF_IDX_R0        5'h00
`define CRF_IDX_R1        5'h01
`define CRF_IDX_R2        5'h02
`define CRF_UNALIGN_BIT   23
`define CRF_RESET_VALUE   32'h00000000
`define CRF_TEXT_NIBBLE   4'h3
`define CRF_BCD_MAX       4'h9
`endif

/* rtl/crf_pkg.sv */
package crf_pkg;
   typedef enum logic [1:0] {
      CRF_SZ_BYTE = 2'b00,
      CRF_SZ_HALF = 2'b01,
      CRF_SZ_WORD = 2'b10,
      CRF_SZ_FLT  = 2'b11
   } crf_size_t;

   typedef enum logic [2:0] {
      CRF_OP_NONE = 3'b000,
      CRF_OP_PUSH = 3'b001,
      CRF_OP_POP  = 3'b010,
      CRF_OP_PCNX = 3'b011,
      CRF_OP_STR  = 3'b100
   } crf_op_t;

   typedef struct packed {
      logic       en;
      logic [4:0] idx;
      logic [31:0] data;
   } crf_wr_t;

   typedef struct packed {
      logic [31:0] r0;
      logic [31:0] r1;
      logic [31:0] r2;
   } crf_str_t;

   typedef struct packed {
      logic [31:0] fp;
      logic [31:0] ap;
   } crf_ptr_t;

   typedef struct packed {
      logic       valid;
      logic [31:0] addr;
      crf_size_t  size;
   } crf_mem_t;
endpackage

/* rtl/crf_regfile.sv */
// Operation
// - r0-r8 and r16-r31 general purpose operands.
// - String and block ops use r0-r2.
// - r12 is stack pointer, next free.
// - Push stores at pointer, then increments.
// - Pop decrements pointer, then reads.
// - r15 holds current, then next, instruction.
// - r9 frame pointer, set by preserve/reload.
// - r10 argument pointer, set by invoke/exit.
// - r11 status word, kernel-only writes.
// - r13 context pointer, kernel-only writes.
// - r14 interrupt stack pointer, kernel-only writes.
// - Halfword address even unless unaligned enabled.
// - Word address multiple of four unless enabled.
// - Misalignment raises internal memory fault.
// - Operand address names its most significant byte.
// - Packed decimal digits limited to 0-9.
// - Unpacked decimal low nibbles, text uses 3.
// - Decimal values treated as unsigned.
// - Field offset 0-31, length width plus one.
// - Field wraps around within one word.
// - Floating operands need four-aligned addresses.
// - r24-r31 readable always, kernel-only writes.
`timescale 1ns/100ps
`include "crf_cfg.svh"
module crf_regfile (
   input  wire logic              sys_clk,        // Processor clock, 25 MHz.
   input  wire logic              resetn,         // Asynchronous reset, active low.
   input  wire logic              kernel_mode,    // High while in kernel level.
   input  wire crf_pkg::crf_wr_t  wr,             // Explicit register write.
   input  wire logic [4:0]        rd_idx_a,       // Read port A index.
   input  wire logic [4:0]        rd_idx_b,       // Read port B index.
   output logic [31:0]            rd_data_a,      // Read port A data.
   output logic [31:0]            rd_data_b,      // Read port B data.
   input  wire crf_pkg::crf_op_t  op,             // Implicit operation.
   input  wire crf_pkg::crf_size_t op_size,       // Operand size.
   input  wire logic [31:0]       pc_next,        // Start of next instruction.
   input  wire crf_pkg::crf_str_t str_in,         // New r0-r2 values for string ops.
   input  wire logic              fp_load,        // Preserve/reload updates frame pointer.
   input  wire logic              ap_load,        // Invoke/exit updates argument pointer.
   input  wire crf_pkg::crf_ptr_t ptr_in,         // New frame/argument pointer values.
   output crf_pkg::crf_mem_t      stack_access,   // Stack memory access request.
   input  wire crf_pkg::crf_mem_t chk,            // Operand address to check.
   output logic                   mem_fault,      // Alignment fault, one-cycle pulse.
   output logic                   priv_fault,     // Privileged write refused, pulse.
   output logic [31:0]            stack_top_pointer,           // Current r12.
   output logic [31:0]            instruction_address_counter, // Current r15.
   output logic [31:0]            processor_status_word,       // Current r11.
   output logic                   unaligned_access_enable,     // Status word bit.
   input  wire logic [4:0]        bf_offset,      // Field least significant bit.
   input  wire logic [4:0]        bf_width,       // Field length minus one.
   input  wire logic [31:0]       bf_src,         // Word holding the field.
   output logic [31:0]            bf_result,      // Zero-extended field.
   input  wire logic [15:0]       bcd_in,         // Decimal operand.
   input  wire logic              bcd_unpacked,   // High for unpacked halfword.
   output logic                   bcd_invalid,    // Digit outside 0-9.
   output logic [7:0]             bcd_packed,     // Digits packed into a byte.
   output logic [15:0]            bcd_text        // Digits in text encoding.
);
   import crf_pkg::*;

   logic [31:0] regs [`CRF_NREGS];
   logic        wr_priv;
   logic        wr_ok;
   logic [31:0] next_sp;
   logic [31:0] size_bytes;
   logic [63:0] bf_double;
   logic [31:0] bf_rot;
   logic [31:0] bf_mask;
   logic        misaligned;

   // Kernel-only targets: status, context and interrupt stack pointers, upper eight.
   always_comb begin
      wr_priv = (wr.idx == `CRF_IDX_STATUS) ||
                (wr.idx == `CRF_IDX_PCB) ||
                (wr.idx == `CRF_IDX_ISTACK) ||
                (wr.idx >= `CRF_IDX_PRIV_LO);
      wr_ok   = wr.en && (kernel_mode || !wr_priv);
   end

   always_comb begin
      case (op_size)
         CRF_SZ_BYTE: size_bytes = 32'h00000001;
         CRF_SZ_HALF: size_bytes = 32'h00000002;
         default:     size_bytes = 32'h00000004;
      endcase
   end

   // Push uses the old pointer as address; pop uses the decremented one.
   always_comb begin
      next_sp = regs[`CRF_IDX_STACK];
      if (op == CRF_OP_PUSH) begin
         next_sp = regs[`CRF_IDX_STACK] + size_bytes;
      end else if (op == CRF_OP_POP) begin
         next_sp = regs[`CRF_IDX_STACK] - size_bytes;
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < `CRF_NREGS; gi = gi + 1) begin : g_reg
         always_ff @(posedge sys_clk or negedge resetn) begin
            if (!resetn) begin
               regs[gi] <= `CRF_RESET_VALUE;
            end else if (gi == `CRF_IDX_STACK && (op == CRF_OP_PUSH || op == CRF_OP_POP)) begin
               regs[gi] <= next_sp;
            end else if (gi == `CRF_IDX_PC && op == CRF_OP_PCNX) begin
               regs[gi] <= pc_next;
            end else if (gi <= `CRF_IDX_R2 && op == CRF_OP_STR) begin
               case (gi)
                  0:       regs[gi] <= str_in.r0;
                  1:       regs[gi] <= str_in.r1;
                  default: regs[gi] <= str_in.r2;
               endcase
            end else if (gi == `CRF_IDX_FRAME && fp_load) begin
               regs[gi] <= ptr_in.fp;
            end else if (gi == `CRF_IDX_ARG && ap_load) begin
               regs[gi] <= ptr_in.ap;
            end else if (wr_ok && wr.idx == gi) begin
               regs[gi] <= wr.data;
            end
         end
      end
   endgenerate

   always_comb begin
      rd_data_a = regs[rd_idx_a];
      rd_data_b = regs[rd_idx_b];
      stack_top_pointer           = regs[`CRF_IDX_STACK];
      instruction_address_counter = regs[`CRF_IDX_PC];
      processor_status_word       = regs[`CRF_IDX_STATUS];
      unaligned_access_enable     = regs[`CRF_IDX_STATUS][`CRF_UNALIGN_BIT];
   end

   always_comb begin
      stack_access.valid = (op == CRF_OP_PUSH) || (op == CRF_OP_POP);
      stack_access.size  = op_size;
      stack_access.addr  = (op == CRF_OP_POP) ? next_sp : regs[`CRF_IDX_STACK];
   end

   // The checked address is that of the most significant byte; its low bits decide.
   always_comb begin
      case (chk.size)
         CRF_SZ_HALF: misaligned = !unaligned_access_enable && chk.addr[0];
         CRF_SZ_WORD: misaligned = !unaligned_access_enable &&
                                   (chk.addr[1:0] != 2'b00);
         CRF_SZ_FLT:  misaligned = (chk.addr[1:0] != 2'b00);
         default:     misaligned = 1'b0;
      endcase
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         mem_fault <= 1'b0;
      end else begin
         mem_fault <= chk.valid && misaligned;
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         priv_fault <= 1'b0;
      end else begin
         priv_fault <= wr.en && !wr_ok;
      end
   end

   // Rotating right by the offset makes a field that passes bit 31 wrap to bit 0.
   always_comb begin
      bf_double = {bf_src, bf_src} >> bf_offset;
      bf_rot    = bf_double[31:0];
      bf_mask   = 32'hFFFFFFFF >> (5'h1F - bf_width);
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         bf_result <= 32'h00000000;
      end else begin
         bf_result <= bf_rot & bf_mask;
      end
   end

   // Decimal digits are unsigned; only the low nibble of each byte counts when unpacked.
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         bcd_invalid <= 1'b0;
         bcd_packed  <= 8'h00;
         bcd_text    <= 16'h0000;
      end else if (bcd_unpacked) begin
         bcd_invalid <= (bcd_in[11:8] > `CRF_BCD_MAX) ||
                        (bcd_in[3:0] > `CRF_BCD_MAX);
         bcd_packed  <= {bcd_in[11:8], bcd_in[3:0]};
         bcd_text    <= {`CRF_TEXT_NIBBLE, bcd_in[11:8],
                         `CRF_TEXT_NIBBLE, bcd_in[3:0]};
      end else begin
         bcd_invalid <= (bcd_in[7:4] > `CRF_BCD_MAX) ||
                        (bcd_in[3:0] > `CRF_BCD_MAX);
         bcd_packed  <= bcd_in[7:0];
         bcd_text    <= {`CRF_TEXT_NIBBLE, bcd_in[7:4],
                         `CRF_TEXT_NIBBLE, bcd_in[3:0]};
      end
   end
endmodule // crf_regfile

/* verif/crf_regfile_checker.sv */
`timescale 1ns/100ps
module crf_regfile_checker
   import crf_pkg::*;
(
   input wire logic               sys_clk,               // Clock.
   input wire logic               resetn,                // Reset.
   input wire logic               kernel_mode,           // Kernel.
   input wire crf_pkg::crf_wr_t   wr,                    // Write.
   input wire crf_pkg::crf_op_t   op,                    // Operation.
   input wire crf_pkg::crf_size_t op_size,               // Size.
   input wire crf_pkg::crf_mem_t  stack_access,          // Stack.
   input wire crf_pkg::crf_mem_t  chk,                   // Check.
   input wire logic               mem_fault,             // Fault.
   input wire logic               priv_fault,            // Refusal.
   input wire logic [31:0]        stack_top_pointer,     // r12.
   input wire logic [31:0]        processor_status_word, // r11.
   input wire logic [4:0]         bf_offset,             // Offset.
   input wire logic [4:0]         bf_width,              // Width.
   input wire logic [31:0]        bf_src,                // Source.
   input wire logic [31:0]        bf_result              // Field.
);
   import crf_pkg::*;
   logic [31:0] step;
   logic [63:0] rot;
   logic        pidx;
   logic        misal;
   assign step = (op_size == CRF_SZ_BYTE) ? 32'h1 : (op_size == CRF_SZ_HALF) ? 32'h2 : 32'h4;
   assign rot = {bf_src, bf_src} >> bf_offset;
   assign pidx = (wr.idx inside {5'h0B, 5'h0D, 5'h0E}) || wr.idx[4:3] == 2'h3;
   assign misal = (chk.size == CRF_SZ_FLT) ? |chk.addr[1:0] : !processor_status_word[23] &&
      ((chk.size == CRF_SZ_WORD) ? |chk.addr[1:0] : chk.size == CRF_SZ_HALF && chk.addr[0]);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   property p_push;
      op == CRF_OP_PUSH |-> stack_access.valid && stack_access.addr == stack_top_pointer
         ##1 stack_top_pointer == $past(stack_top_pointer) + $past(step);
   endproperty
   a_push: assert property (p_push) else $error("push order wrong");
   property p_pop;
      op == CRF_OP_POP |-> stack_access.addr == stack_top_pointer - step
         ##1 stack_top_pointer == $past(stack_access.addr);
   endproperty
   a_pop: assert property (p_pop) else $error("pop order wrong");
   property p_priv;
      wr.en && !kernel_mode && pidx |=> priv_fault;
   endproperty
   a_priv: assert property (p_priv) else $error("no refusal");
   property p_keep;
      wr.en && !kernel_mode && wr.idx == 5'h0B |=> $stable(processor_status_word);
   endproperty
   a_keep: assert property (p_keep) else $error("status word changed");
   property p_allow;
      wr.en && (kernel_mode || !pidx) |=> !priv_fault;
   endproperty
   a_allow: assert property (p_allow) else $error("false refusal");
   property p_misal;
      chk.valid && misal |=> mem_fault;
   endproperty
   a_misal: assert property (p_misal) else $error("no fault");
   property p_align;
      chk.valid && !misal |=> !mem_fault;
   endproperty
   a_align: assert property (p_align) else $error("false fault");
   property p_field;
      ##1 bf_result == ($past(rot[31:0]) & ~(32'hFFFFFFFE << $past(bf_width)));
   endproperty
   a_field: assert property (p_field) else $error("field wrong");
endmodule // crf_regfile_checker

bind crf_regfile crf_regfile_checker crf_regfile_checker_inst (.sys_clk, .resetn, .kernel_mode,
   .wr, .op, .op_size, .stack_access, .chk, .mem_fault, .priv_fault, .stack_top_pointer,
   .processor_status_word, .bf_offset, .bf_width, .bf_src, .bf_result);

/* verif/tb.sv */
`timescale 1ns/100ps
module tb;
   import crf_pkg::*;
   logic sys_clk = 1'h0, resetn = 1'h0, kernel_mode = 1'h0, fp_load = 1'h0, ap_load = 1'h0;
   logic bcd_unpacked = 1'h0, mem_fault, priv_fault, unaligned_access_enable, bcd_invalid;
   logic [4:0] rd_idx_a = '0, rd_idx_b = '0, bf_offset = '0, bf_width = '0;
   logic [31:0] pc_next = '0, bf_src = '0, rd_data_a, rd_data_b, bf_result;
   logic [31:0] stack_top_pointer, instruction_address_counter, processor_status_word;
   logic [15:0] bcd_in = '0, bcd_text;
   logic [7:0] bcd_packed;
   crf_wr_t wr = '0;
   crf_op_t op = CRF_OP_NONE;
   crf_size_t op_size = CRF_SZ_BYTE;
   crf_str_t str_in = '0;
   crf_ptr_t ptr_in = '0;
   crf_mem_t chk = '0, stack_access;
   int fail_count = 0, checks = 0;
   crf_regfile crf_regfile_inst (.sys_clk, .resetn, .kernel_mode, .wr, .rd_idx_a, .rd_idx_b,
      .rd_data_a, .rd_data_b, .op, .op_size, .pc_next, .str_in, .fp_load, .ap_load, .ptr_in,
      .stack_access, .chk, .mem_fault, .priv_fault, .stack_top_pointer,
      .instruction_address_counter, .processor_status_word, .unaligned_access_enable,
      .bf_offset, .bf_width, .bf_src, .bf_result, .bcd_in, .bcd_unpacked, .bcd_invalid,
      .bcd_packed, .bcd_text);
   initial forever #20 sys_clk = ~sys_clk;
   task check(input string n, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         fail_count++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask
   task stop_test;
      $display("checks %0d fail_count %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task wreg(input logic k, input logic [4:0] i, input logic [31:0] d, input logic f);
      @(posedge sys_clk);
      kernel_mode <= k;
      wr <= '{1'h1, i, d};
      @(posedge sys_clk);
      wr <= '0;
      #1;
      check("priv_fault", {31'h0, f}, priv_fault);
   endtask
   task rd(input logic [4:0] i, input logic [31:0] e);
      @(posedge sys_clk);
      rd_idx_a <= i;
      rd_idx_b <= i;
      #1;
      check("rd_data_a", e, rd_data_a);
      check("rd_data_b", e, rd_data_b);
   endtask
   task t_priv;
      logic [4:0] p [5] = '{5'h0B, 5'h0D, 5'h0E, 5'h18, 5'h1F};
      wreg(1'h0, 5'h03, 32'hA5A50003, 1'h0);
      rd(5'h03, 32'hA5A50003);
      wreg(1'h1, 5'h18, 32'h12345678, 1'h0);
      rd(5'h18, 32'h12345678);
      foreach (p[j]) begin
         wreg(1'h0, p[j], 32'hFFFFFFFF, 1'h1);
         rd(p[j], (p[j] == 5'h18) ? 32'h12345678 : 32'h0);
      end
   endtask
   task stk(input crf_op_t o, input crf_size_t s, input logic [31:0] a, input logic [31:0] sp);
      @(posedge sys_clk);
      op <= o;
      op_size <= s;
      #1;
      check("stack_access.addr", a, stack_access.addr);
      @(posedge sys_clk);
      op <= CRF_OP_NONE;
      #1;
      check("stack_top_pointer", sp, stack_top_pointer);
   endtask
   task t_misc;
      @(posedge sys_clk);
      op <= CRF_OP_PCNX;
      pc_next <= 32'h00001000;
      @(posedge sys_clk);
      op <= CRF_OP_STR;
      str_in <= '{32'h11, 32'h22, 32'h33};
      {fp_load, ap_load} <= 2'h3;
      ptr_in <= '{32'h99, 32'hAA};
      #1;
      check("instruction_address_counter", 32'h1000, instruction_address_counter);
      @(posedge sys_clk);
      op <= CRF_OP_NONE;
      {fp_load, ap_load} <= 2'h0;
      rd(5'h00, 32'h11);
      rd(5'h01, 32'h22);
      rd(5'h02, 32'h33);
      rd(5'h09, 32'h99);
      rd(5'h0A, 32'hAA);
   endtask
   task al(input crf_size_t s, input logic [31:0] a, input logic f);
      @(posedge sys_clk);
      chk <= '{1'h1, a, s};
      @(posedge sys_clk);
      chk <= '0;
      #1;
      check("mem_fault", {31'h0, f}, mem_fault);
   endtask
   task bf(input logic [4:0] o, input logic [4:0] w, input logic [31:0] s, input logic [31:0] e);
      @(posedge sys_clk);
      {bf_offset, bf_width, bf_src} <= {o, w, s};
      @(posedge sys_clk);
      #1;
      check("bf_result", e, bf_result);
   endtask
   task bcd(input logic u, input logic [15:0] i, input logic v, input logic [7:0] p);
      @(posedge sys_clk);
      {bcd_unpacked, bcd_in} <= {u, i};
      @(posedge sys_clk);
      #1;
      check("bcd_invalid", {31'h0, v}, bcd_invalid);
      if (!v) begin
         check("bcd_packed", {24'h0, p}, bcd_packed);
         check("bcd_text", {16'h0, 4'h3, p[7:4], 4'h3, p[3:0]}, bcd_text);
      end
   endtask
   initial begin
      repeat (6) @(posedge sys_clk);
      resetn <= 1'h1;
      t_priv;
      stk(CRF_OP_PUSH, CRF_SZ_WORD, 32'h0, 32'h4);
      stk(CRF_OP_PUSH, CRF_SZ_BYTE, 32'h4, 32'h5);
      stk(CRF_OP_PUSH, CRF_SZ_HALF, 32'h5, 32'h7);
      stk(CRF_OP_POP, CRF_SZ_HALF, 32'h5, 32'h5);
      stk(CRF_OP_POP, CRF_SZ_FLT, 32'h1, 32'h1);
      t_misc;
      al(CRF_SZ_HALF, 32'h1, 1'h1);
      al(CRF_SZ_HALF, 32'h2, 1'h0);
      al(CRF_SZ_WORD, 32'h2, 1'h1);
      al(CRF_SZ_WORD, 32'h4, 1'h0);
      wreg(1'h1, 5'h0B, 32'h00800000, 1'h0);
      check("unaligned_access_enable", 32'h1, {31'h0, unaligned_access_enable});
      al(CRF_SZ_WORD, 32'h3, 1'h0);
      al(CRF_SZ_FLT, 32'h6, 1'h1);
      bf(5'd6, 5'd9, 32'h0000FFC0, 32'h3FF);
      bf(5'd30, 5'd3, 32'hC0000001, 32'h7);
      bf(5'd0, 5'd31, 32'hDEADBEEF, 32'hDEADBEEF);
      bcd(1'h0, 16'h0059, 1'h0, 8'h59);
      bcd(1'h1, 16'h3735, 1'h0, 8'h75);
      bcd(1'h0, 16'h005A, 1'h1, 8'h00);
      stop_test;
   end
   initial begin
      repeat (5000) @(posedge sys_clk);
      fail_count++;
      stop_test;
   end
endmodule // tb
